// [shared/fub_defines.vh]
// Constants for the dual FIFO serial controller.
// Assumes inclusion by bare name from the core file.
`ifndef FUB_DEFINES_VH
`define FUB_DEFINES_VH
`define FUB_A_BUF 3'h0
`define FUB_A_IER 3'h1
`define FUB_A_IIR 3'h2
`define FUB_A_LCR 3'h3
`define FUB_A_MCR 3'h4
`define FUB_A_LSR 3'h5
`define FUB_A_MSR 3'h6
`define FUB_A_SCR 3'h7
`define FUB_IER_MASK 8'h87
`define FUB_IER_RDA 0
`define FUB_IER_THR 1
`define FUB_IER_RLS 2
`define FUB_IER_PROG_TX_EMPTY_IRQ_MODE 7
`define FUB_LCR_PEN 3
`define FUB_LCR_EPS 4
`define FUB_LCR_STB 2
`define FUB_LCR_BRK 6
`define FUB_LCR_DIVISOR_LATCH_ACCESS_BIT 7
`define FUB_FCR_EN 0
`define FUB_FCR_RXCLR 1
`define FUB_FCR_TXCLR 2
`define FUB_IIR_NONE 4'h1
`define FUB_IIR_RLS 4'h6
`define FUB_IIR_RDA 4'h4
`define FUB_IIR_TOUT 4'hc
`define FUB_IIR_THR 4'h2
`define FUB_IIR_FIFO 2'h3
`define FUB_RST8 8'h00
`define FUB_DEPTH 5'h10
`define FUB_LAST_TICK 4'hf
`define FUB_MID_TICK 4'h7
`define FUB_TOUT_TICKS 10'h280
`endif

// [core/fub_top.v]
// Two identical serial controllers with 16-byte FIFOs and a 16x baud divisor.
// Assumes I_RXD comes from pins (synchronised inside) and a single 40 MHz clock.
// Overview of operation
// - Two independent identical controllers, each with own receive and transmit pins.
// - Each controller has a sixteen byte receive FIFO and transmit FIFO.
// - Line control sets character length, parity enable, parity sense, stop bits.
// - Bit rate is clock divided by sixteen times the divisor.
// - Divisor zero stops the baud generator; nothing is sent or received.
// - Divisor is zero after reset, so the link is idle until programmed.
// - With latch access set, buffer and enable addresses reach divisor bytes.
// - FIFO mode is off after reset; software should enable it.
// - Handshake lines exist internally only; no hardware flow control at pins.
// - Enabled events interrupt in order: error, data, timeout, transmit level.
// - Character timeout interrupt works only in FIFO mode.
// - Ident address reads pending source in bits 0-3, writes FIFO control.
// - Transmit trigger field picks threshold, 10 is quarter, FIFO mode only.
// - Programmable mode: transmit interrupt when FIFO at or below threshold.
`include "fub_defines.vh"
`default_nettype none

module fub_chan (
  input wire i_clk,          // System clock.
  input wire i_rst,          // Synchronous reset, high.
  input wire i_wr,           // Register write strobe.
  input wire i_rd,           // Register read strobe.
  input wire [2:0] i_addr,   // Register address.
  input wire [7:0] i_wdata,  // Write data.
  output reg [7:0] o_rdata,  // Read data, combinational.
  input wire i_rxd,          // Receive pin.
  output reg o_txd,          // Transmit pin.
  output reg o_irq           // Interrupt request.
);
  localparam S_IDLE = 5'h01;
  localparam S_START = 5'h02;
  localparam S_DATA = 5'h04;
  localparam S_PAR = 5'h08;
  localparam S_STOP = 5'h10;

  function [7:0] wmask;
    input [1:0] wls;
    begin
      wmask = {wls == 2'h3, wls >= 2'h2, wls != 2'h0, 5'h1f};
    end
  endfunction

  function [2:0] lastbit;
    input [1:0] wls;
    begin
      lastbit = {1'b0, wls} + 3'h4;
    end
  endfunction

  reg [7:0] dll_q, dlm_q, ier_q, lcr_q, mcr_q, scr_q;
  reg fifo_en_q;
  reg [1:0] tet_q, rtrig_q;
  reg [15:0] bcnt_q;
  reg tick_q;
  reg [7:0] txm [0:15];
  reg [7:0] rxm [0:15];
  reg [4:0] twp_q, trp_q, rwp_q, rrp_q;
  reg [4:0] ts_q, rs_q;
  reg [3:0] t16_q, r16_q;
  reg [2:0] tbit_q, rbit_q;
  reg tstop_q;
  reg [7:0] tsh_q, rsh_q;
  reg tpar_q, rpar_q, rhi_q, rx1_q, rx2_q;
  reg oe_q, pe_q, fe_q, bi_q;
  reg [9:0] to_q;
  reg tline;
  reg [3:0] iir;
  wire divisor_latch_access_bit = lcr_q[`FUB_LCR_DIVISOR_LATCH_ACCESS_BIT];
  wire [15:0] div = {dlm_q, dll_q};
  wire [4:0] tlev = twp_q - trp_q;
  wire [4:0] rlev = rwp_q - rrp_q;
  wire wr_buf = i_wr && i_addr == `FUB_A_BUF && !divisor_latch_access_bit;
  wire rd_buf = i_rd && i_addr == `FUB_A_BUF && !divisor_latch_access_bit;
  wire wr_fcr = i_wr && i_addr == `FUB_A_IIR;
  wire rd_lsr = i_rd && i_addr == `FUB_A_LSR;
  // Without FIFO mode each FIFO behaves as a single holding register.
  wire tx_full = fifo_en_q ? (tlev == `FUB_DEPTH) : (tlev != 5'h00);
  wire rx_full = fifo_en_q ? (rlev == `FUB_DEPTH) : (rlev != 5'h00);
  wire fen_chg = wr_fcr && (i_wdata[`FUB_FCR_EN] != fifo_en_q);
  wire tx_clr = wr_fcr && (i_wdata[`FUB_FCR_TXCLR] || fen_chg);
  wire rx_clr = wr_fcr && (i_wdata[`FUB_FCR_RXCLR] || fen_chg);
  wire tx_pop = tick_q && ts_q == S_IDLE && tlev != 5'h00;
  wire rx_done = tick_q && rs_q == S_STOP && r16_q == `FUB_LAST_TICK;
  wire rx_push = rx_done && !rx_full;
  wire rx_pop = rd_buf && rlev != 5'h00;
  wire [1:0] wls = lcr_q[1:0];
  wire pen = lcr_q[`FUB_LCR_PEN];
  wire eps = lcr_q[`FUB_LCR_EPS];
  wire [7:0] rdat = rsh_q & wmask(wls);
  wire brk = rdat == 8'h00 && !rx2_q && (!pen || !rpar_q);
  wire ferr = !rx2_q;
  wire perr = pen && (rpar_q != ((^rdat) ^ !eps));
  wire temt = ts_q == S_IDLE && tlev == 5'h00;
  wire tout = fifo_en_q && to_q == `FUB_TOUT_TICKS;
  reg [4:0] rthr, tthr;

  // Register writes; latch access redirects the two low addresses.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dll_q <= `FUB_RST8;
      dlm_q <= `FUB_RST8;
      ier_q <= `FUB_RST8;
      lcr_q <= `FUB_RST8;
      mcr_q <= `FUB_RST8;
      scr_q <= `FUB_RST8;
      fifo_en_q <= 1'b0;
      tet_q <= 2'h0;
      rtrig_q <= 2'h0;
    end
    else if (i_wr)
    begin
      case (i_addr)
        `FUB_A_BUF: if (divisor_latch_access_bit) dll_q <= i_wdata;
        `FUB_A_IER:
        begin
          if (divisor_latch_access_bit)
            dlm_q <= i_wdata;
          else
            ier_q <= i_wdata & `FUB_IER_MASK;
        end
        `FUB_A_IIR:
        begin
          fifo_en_q <= i_wdata[`FUB_FCR_EN];
          tet_q <= i_wdata[5:4];
          rtrig_q <= i_wdata[7:6];
        end
        `FUB_A_LCR: lcr_q <= i_wdata;
        // Handshake bits are stored but never reach a pin.
        `FUB_A_MCR: mcr_q <= i_wdata;
        `FUB_A_SCR: scr_q <= i_wdata;
        default: scr_q <= scr_q;
      endcase
    end
  end

  // One tick per divisor period gives sixteen ticks per bit.
  always @(posedge i_clk)
  begin
    if (i_rst || div == 16'h0000)
    begin
      bcnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else if (bcnt_q >= div - 16'h0001)
    begin
      bcnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end
    else
    begin
      bcnt_q <= bcnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // Transmit FIFO storage.
  always @(posedge i_clk)
  begin
    if (i_rst || tx_clr)
    begin
      twp_q <= 5'h00;
    end
    else if (wr_buf && !tx_full)
    begin
      txm[twp_q[3:0]] <= i_wdata;
      twp_q <= twp_q + 5'h01;
    end
  end

  // Transmitter: one state per frame field, sixteen ticks per bit.
  always @(posedge i_clk)
  begin
    if (i_rst || tx_clr)
    begin
      ts_q <= S_IDLE;
      trp_q <= 5'h00;
      t16_q <= 4'h0;
      tbit_q <= 3'h0;
      tstop_q <= 1'b0;
      tsh_q <= 8'h00;
      tpar_q <= 1'b0;
    end
    else if (tick_q)
    begin
      t16_q <= t16_q + 4'h1;
      case (ts_q)
        S_IDLE:
        begin
          t16_q <= 4'h0;
          if (tx_pop)
          begin
            tsh_q <= txm[trp_q[3:0]];
            tpar_q <= (^(txm[trp_q[3:0]] & wmask(wls))) ^ !eps;
            trp_q <= trp_q + 5'h01;
            ts_q <= S_START;
          end
        end
        S_START:
        begin
          if (t16_q == `FUB_LAST_TICK)
          begin
            tbit_q <= 3'h0;
            ts_q <= S_DATA;
          end
        end
        S_DATA:
        begin
          if (t16_q == `FUB_LAST_TICK)
          begin
            tsh_q <= {1'b0, tsh_q[7:1]};
            tbit_q <= tbit_q + 3'h1;
            if (tbit_q == lastbit(wls))
            begin
              tstop_q <= lcr_q[`FUB_LCR_STB];
              ts_q <= pen ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR:
        begin
          if (t16_q == `FUB_LAST_TICK)
            ts_q <= S_STOP;
        end
        S_STOP:
        begin
          if (t16_q == `FUB_LAST_TICK)
          begin
            tstop_q <= 1'b0;
            if (!tstop_q)
              ts_q <= S_IDLE;
          end
        end
        default: ts_q <= S_IDLE;
      endcase
    end
  end

  always @*
  begin
    case (ts_q)
      S_START: tline = 1'b0;
      S_DATA: tline = tsh_q[0];
      S_PAR: tline = tpar_q;
      default: tline = 1'b1;
    endcase
  end

  // Receiver, fed from a two-stage synchroniser.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rx1_q <= 1'b1;
      rx2_q <= 1'b1;
    end
    else
    begin
      rx1_q <= i_rxd;
      rx2_q <= rx1_q;
    end
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rs_q <= S_IDLE;
      r16_q <= 4'h0;
      rbit_q <= 3'h0;
      rsh_q <= 8'h00;
      rpar_q <= 1'b0;
      rhi_q <= 1'b0;
    end
    else if (tick_q)
    begin
      r16_q <= r16_q + 4'h1;
      case (rs_q)
        S_IDLE:
        begin
          r16_q <= 4'h0;
          rsh_q <= 8'h00;
          // A held break must return high before another frame starts.
          if (rx2_q)
            rhi_q <= 1'b1;
          else if (rhi_q)
          begin
            rhi_q <= 1'b0;
            rs_q <= S_START;
          end
        end
        S_START:
        begin
          if (r16_q == `FUB_MID_TICK)
          begin
            r16_q <= 4'h0;
            rbit_q <= 3'h0;
            rs_q <= rx2_q ? S_IDLE : S_DATA;
          end
        end
        S_DATA:
        begin
          if (r16_q == `FUB_LAST_TICK)
          begin
            rsh_q[rbit_q] <= rx2_q;
            rbit_q <= rbit_q + 3'h1;
            if (rbit_q == lastbit(wls))
              rs_q <= pen ? S_PAR : S_STOP;
          end
        end
        S_PAR:
        begin
          if (r16_q == `FUB_LAST_TICK)
          begin
            rpar_q <= rx2_q;
            rs_q <= S_STOP;
          end
        end
        S_STOP:
        begin
          if (r16_q == `FUB_LAST_TICK)
            rs_q <= S_IDLE;
        end
        default: rs_q <= S_IDLE;
      endcase
    end
  end

  // Receive FIFO, sticky line errors and the character timeout.
  always @(posedge i_clk)
  begin
    if (i_rst || rx_clr)
    begin
      rwp_q <= 5'h00;
      rrp_q <= 5'h00;
      to_q <= 10'h000;
    end
    else
    begin
      if (rx_push)
      begin
        rxm[rwp_q[3:0]] <= rdat;
        rwp_q <= rwp_q + 5'h01;
      end
      if (rx_pop)
        rrp_q <= rrp_q + 5'h01;
      if (rx_push || rx_pop || rlev == 5'h00)
        to_q <= 10'h000;
      else if (tick_q && !tout)
        to_q <= to_q + 10'h001;
    end
  end

  // A new error in the same cycle as the status read stays set.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      oe_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      bi_q <= 1'b0;
    end
    else
    begin
      oe_q <= (rx_done && rx_full) || (oe_q && !rd_lsr);
      pe_q <= (rx_done && perr) || (pe_q && !rd_lsr);
      fe_q <= (rx_done && ferr) || (fe_q && !rd_lsr);
      bi_q <= (rx_done && brk) || (bi_q && !rd_lsr);
    end
  end

  // Interrupt source selection in fixed priority.
  always @*
  begin
    case (rtrig_q)
      2'h0: rthr = 5'h01;
      2'h1: rthr = 5'h04;
      2'h2: rthr = 5'h08;
      default: rthr = 5'h0e;
    endcase
    case (tet_q)
      2'h0: tthr = 5'h00;
      2'h1: tthr = 5'h02;
      2'h2: tthr = 5'h04;
      default: tthr = 5'h08;
    endcase
    // Threshold only counts with FIFO mode; otherwise plain empty.
    if (!ier_q[`FUB_IER_PROG_TX_EMPTY_IRQ_MODE] || !fifo_en_q)
      tthr = 5'h00;
    if (!fifo_en_q)
      rthr = 5'h01;
    if (ier_q[`FUB_IER_RLS] && (oe_q || pe_q || fe_q || bi_q))
      iir = `FUB_IIR_RLS;
    else if (ier_q[`FUB_IER_RDA] && rlev >= rthr)
      iir = `FUB_IIR_RDA;
    else if (ier_q[`FUB_IER_RDA] && tout)
      iir = `FUB_IIR_TOUT;
    else if (ier_q[`FUB_IER_THR] && tlev <= tthr)
      iir = `FUB_IIR_THR;
    else
      iir = `FUB_IIR_NONE;
  end

  always @*
  begin
    case (i_addr)
      `FUB_A_BUF: o_rdata = divisor_latch_access_bit ? dll_q : rxm[rrp_q[3:0]];
      `FUB_A_IER: o_rdata = divisor_latch_access_bit ? dlm_q : ier_q;
      `FUB_A_IIR: o_rdata = {fifo_en_q ? `FUB_IIR_FIFO : 2'h0, 2'h0, iir};
      `FUB_A_LCR: o_rdata = lcr_q;
      `FUB_A_MCR: o_rdata = mcr_q;
      `FUB_A_LSR: o_rdata = {fifo_en_q && (pe_q || fe_q || bi_q), temt, tlev == 5'h00,
                              bi_q, fe_q, pe_q, oe_q, rlev != 5'h00};
      `FUB_A_SCR: o_rdata = scr_q;
      default: o_rdata = 8'h00;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_txd <= 1'b1;
      o_irq <= 1'b0;
    end
    else
    begin
      o_txd <= tline && !lcr_q[`FUB_LCR_BRK];
      o_irq <= iir != `FUB_IIR_NONE;
    end
  end
endmodule // fub_chan

module fub_top (
  input wire I_MCLK,         // 40 MHz system clock.
  input wire I_RST,          // Synchronous reset, high.
  input wire I_CH,           // Selects controller 0 or 1.
  input wire [2:0] I_ADDR,   // Register address.
  input wire I_WR,           // Write strobe, one cycle.
  input wire I_RD,           // Read strobe, one cycle.
  input wire [7:0] I_WDATA,  // Write data.
  output reg [7:0] O_RDATA,  // Read data, one cycle after I_RD.
  input wire [1:0] I_RXD,    // Receive pins per controller.
  output wire [1:0] O_TXD,   // Transmit pins, flop driven.
  output wire [1:0] O_IRQ    // Interrupts, flop driven.
);
  // Read data of controller g sits in byte g.
  wire [15:0] rdv;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ch
      fub_chan u_chan (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_wr(I_WR && (I_CH == (g == 1))),
        .i_rd(I_RD && (I_CH == (g == 1))),
        .i_addr(I_ADDR),
        .i_wdata(I_WDATA),
        .o_rdata(rdv[8 * g + 7:8 * g]),
        .i_rxd(I_RXD[g]),
        .o_txd(O_TXD[g]),
        .o_irq(O_IRQ[g])
      );
    end
  endgenerate

  always @(posedge I_MCLK)
  begin
    if (I_RST)
      O_RDATA <= 8'h00;
    else if (I_RD)
      O_RDATA <= I_CH ? rdv[15:8] : rdv[7:0];
  end
endmodule // fub_top
`default_nettype wire

// [testbench/fub_chk.sv]
// Port checker for the dual serial controller.
// Assumes the bind at the foot and a single clock domain.
`default_nettype none
module fub_chk (
  input wire logic I_MCLK,        // Clock.
  input wire logic I_RST,         // Reset, high.
  input wire logic I_CH,          // Controller select.
  input wire logic [2:0] I_ADDR,  // Address.
  input wire logic I_WR,          // Write strobe.
  input wire logic I_RD,          // Read strobe.
  input wire logic [7:0] I_WDATA, // Write data.
  input wire logic [7:0] O_RDATA, // Read data.
  input wire logic [1:0] I_RXD,   // Receive pins.
  input wire logic [1:0] O_TXD,   // Transmit pins.
  input wire logic [1:0] O_IRQ    // Interrupts.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0][15:0] dv;
  logic [1:0][7:0] ie;
  logic [1:0][7:0] sc;
  logic [1:0] dl;
  logic [1:0] fe;
  always_ff @(posedge I_MCLK)
    if (I_RST)
    begin
      dv <= '0;
      ie <= '0;
      sc <= '0;
      dl <= 2'h0;
      fe <= 2'h0;
    end
    else if (I_WR)
    begin
      case (I_ADDR)
        3'h0:
          if (dl[I_CH])
            dv[I_CH][7:0] <= I_WDATA;
        3'h1:
          if (dl[I_CH])
            dv[I_CH][15:8] <= I_WDATA;
          else
            ie[I_CH] <= I_WDATA & 8'h87;
        3'h2: fe[I_CH] <= I_WDATA[0];
        3'h3: dl[I_CH] <= I_WDATA[7];
        3'h7: sc[I_CH] <= I_WDATA;
        default: ;
      endcase
    end
  wire logic [1:0] z = {dv[1] == 16'h0, dv[0] == 16'h0};
  wire logic m0 = ie[0] == 8'h00;
  wire logic [7:0] dll = dv[I_CH][7:0];
  wire logic [7:0] ssel = sc[I_CH];
  wire logic dsel = dl[I_CH];
  wire logic fsel = fe[I_CH];
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  reset_state_a: assert property (disable iff (1'b0) I_RST |=>
    O_TXD == 2'h3 && O_IRQ == 2'h0 && O_RDATA == 8'h00) else $error("bad reset state");
  rdata_hold_a: assert property (!I_RD |=> $stable(O_RDATA))
    else $error("read data moved without a read");
  scratch_read_a: assert property (I_RD && I_ADDR == 3'h7 |=> O_RDATA == $past(ssel))
    else $error("scratch readback wrong");
  div_read_a: assert property (I_RD && I_ADDR == 3'h0 && dsel |=> O_RDATA == $past(dll))
    else $error("divisor low readback wrong");
  ident_mode_a: assert property (I_RD && I_ADDR == 3'h2 |=>
    O_RDATA[7:4] == ($past(fsel) ? 4'hc : 4'h0)) else $error("ident mode bits wrong");
  modem_zero_a: assert property (I_RD && I_ADDR == 3'h6 |=> O_RDATA == 8'h00)
    else $error("modem status not zero");
  halt_tx0_a: assert property (z[0] [*4] |-> $stable(O_TXD[0]))
    else $error("line 0 moved with zero divisor");
  halt_tx1_a: assert property (z[1] [*4] |-> $stable(O_TXD[1]))
    else $error("line 1 moved with zero divisor");
  irq_masked_a: assert property (m0 [*3] |-> !O_IRQ[0])
    else $error("interrupt with all sources disabled");
endmodule // fub_chk
bind fub_top fub_chk fub_chk_i (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CH(I_CH), .I_ADDR(I_ADDR),
  .I_WR(I_WR), .I_RD(I_RD), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .I_RXD(I_RXD),
  .O_TXD(O_TXD), .O_IRQ(O_IRQ));
`default_nettype wire

// [testbench/fub_peer.sv]
// Remote serial peer: drives one receive line and decodes one transmit line.
// Assumes a bit lasts BIT clocks; the line idles high.
`default_nettype none
module fub_peer #(
  parameter int BIT = 32
) (
  input wire logic i_clk,  // System clock.
  input wire logic i_line, // Line from the controller.
  output logic o_line      // Line into the controller.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_line = 1'b1;
  task automatic send(input logic [7:0] d, input int n, input logic pe, input logic pb);
    @(posedge i_clk);
    o_line <= 1'b0;
    repeat (BIT) @(posedge i_clk);
    for (int k = 0; k < n; k++)
    begin
      o_line <= d[k];
      repeat (BIT) @(posedge i_clk);
    end
    if (pe)
    begin
      o_line <= pb;
      repeat (BIT) @(posedge i_clk);
    end
    o_line <= 1'b1;
    repeat (BIT) @(posedge i_clk);
  endtask
  // A missing start bit shows up as ok low rather than a hang.
  task automatic recv(output logic [7:0] d, output logic ok);
    logic s;
    for (int w = 0; w < 8000 && i_line !== 1'b0; w++)
      @(posedge i_clk);
    repeat (BIT / 2) @(posedge i_clk);
    s = i_line;
    for (int k = 0; k < 8; k++)
    begin
      repeat (BIT) @(posedge i_clk);
      d[k] = i_line;
    end
    repeat (BIT) @(posedge i_clk);
    ok = s === 1'b0 && i_line === 1'b1;
  endtask
endmodule // fub_peer
`default_nettype wire

// [testbench/fub_top_bench.sv]
// Testbench for the dual serial controller, with one peer per controller.
// Assumes the peers run at divisor 2, i.e. 32 clocks a bit.
`default_nettype none
module fub_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic C0 = 1'b0;
  localparam logic C1 = 1'b1;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ch = 1'b0;
  logic [2:0] addr = 3'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  wire [7:0] rdata;
  wire [1:0] rxd;
  wire [1:0] txd;
  wire [1:0] irq;
  logic [7:0] v;
  logic [7:0] b;
  logic ok;
  int n_fail = 0;
  int comparisons = 0;
  fub_top fub_top_i (.I_MCLK(clk), .I_RST(rst), .I_CH(ch), .I_ADDR(addr), .I_WR(wr),
    .I_RD(rd), .I_WDATA(wdata), .O_RDATA(rdata), .I_RXD(rxd), .O_TXD(txd), .O_IRQ(irq));
  fub_peer p0 (.i_clk(clk), .i_line(txd[0]), .o_line(rxd[0]));
  fub_peer p1 (.i_clk(clk), .i_line(txd[1]), .o_line(rxd[1]));
  initial forever #12.5 clk = ~clk;
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic c, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    ch <= c;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic c, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    ch <= c;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask
  task automatic setdiv(input logic c, input logic [7:0] d, input logic [7:0] line_control_reg);
    wr_reg(c, 3'h3, 8'h83);
    wr_reg(c, 3'h0, d);
    wr_reg(c, 3'h1, 8'h00);
    rdc(c, 3'h0, d);
    wr_reg(c, 3'h3, line_control_reg);
  endtask
  task automatic wirq(input int c);
    for (int w = 0; w < 5000 && irq[c] !== 1'b1; w++)
      @(posedge clk);
    if (irq[c] !== 1'b1)
    begin
      $display("Error at %0t: interrupt never rose", $time);
      n_fail++;
      results();
    end
  endtask
  task automatic irqis(input int c, input logic e);
    repeat (2) @(posedge clk);
    #1;
    cmp({7'h0, irq[c]}, {7'h0, e});
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    $display("Error at %0t: run timed out", $time);
    n_fail++;
    results();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    cmp({4'h0, txd, irq}, 8'h0c);
    cmp(rdata, 8'h00);
    rdc(C0, 3'h2, 8'h01);
    wr_reg(C0, 3'h3, 8'h80);
    rdc(C0, 3'h1, 8'h00);
    wr_reg(C0, 3'h3, 8'h03);
    wr_reg(C0, 3'h0, 8'h5a);
    repeat (200) @(posedge clk);
    cmp({6'h0, txd}, 8'h03);
    done("reset");
    fork
      p0.recv(v, ok);
      setdiv(C0, 8'h02, 8'h03);
    join
    cmp(v, 8'h5a);
    cmp({7'h0, ok}, 8'h01);
    // Seven data bits, even parity; 0x35 has four ones so parity is low.
    wr_reg(C0, 3'h3, 8'h1a);
    wr_reg(C0, 3'h1, 8'h01);
    p0.send(8'h35, 7, 1'b1, 1'b0);
    wirq(0);
    rdc(C0, 3'h2, 8'h04);
    rdc(C0, 3'h0, 8'h35);
    irqis(0, 1'b0);
    wr_reg(C0, 3'h1, 8'h05);
    p0.send(8'h35, 7, 1'b1, 1'b1);
    wirq(0);
    rdc(C0, 3'h2, 8'h06);
    rdc(C0, 3'h5, 8'h65);
    rdc(C0, 3'h0, 8'h35);
    rdc(C0, 3'h2, 8'h01);
    done("link");
    setdiv(C0, 8'h00, 8'h03);
    wr_reg(C0, 3'h2, 8'he1);
    wr_reg(C0, 3'h1, 8'h82);
    irqis(0, 1'b1);
    rdc(C0, 3'h2, 8'hc2);
    for (b = 8'h10; b < 8'h15; b++)
      wr_reg(C0, 3'h0, b);
    irqis(0, 1'b0);
    rdc(C0, 3'h2, 8'hc1);
    fork
      for (b = 8'h10; b < 8'h15; b++)
      begin
        p0.recv(v, ok);
        cmp(v, b);
      end
      begin
        setdiv(C0, 8'h02, 8'h03);
        wirq(0);
        rdc(C0, 3'h2, 8'hc2);
      end
    join
    wr_reg(C0, 3'h1, 8'h01);
    p0.send(8'h3c, 8, 1'b0, 1'b0);
    rdc(C0, 3'h2, 8'hc1);
    wirq(0);
    rdc(C0, 3'h2, 8'hcc);
    rdc(C0, 3'h0, 8'h3c);
    done("fifo");
    setdiv(C1, 8'h02, 8'h03);
    fork
      p1.recv(v, ok);
      wr_reg(C1, 3'h0, 8'h96);
    join
    cmp(v, 8'h96);
    wr_reg(C1, 3'h7, 8'ha5);
    rdc(C1, 3'h7, 8'ha5);
    rdc(C1, 3'h6, 8'h00);
    // Five bits, odd parity; the second character finds the holding byte full.
    wr_reg(C1, 3'h3, 8'h08);
    p1.send(8'h15, 5, 1'b1, 1'b0);
    p1.send(8'h0a, 5, 1'b1, 1'b1);
    rdc(C1, 3'h5, 8'h63);
    rdc(C1, 3'h0, 8'h15);
    done("second");
    results();
  end
endmodule // fub_top_bench
`default_nettype wire
